/* pqls_pkg.sv */
// Package with the register map, field layout and carrier types of the port status register bank.
package pqls_pkg;

  // ********************************************************************
  // Register map.
  // ********************************************************************
  localparam int ADR_W = 16;
  localparam int DAT_W = 32;
  localparam logic [11:0] CTRL_OFS = 12'h020;
  localparam logic [11:0] STAT_OFS = 12'h030;
  localparam logic [3:0] PHY_PAGE = 4'h1;
  localparam logic [2:0] FIRST_PORT = 3'h1;
  localparam int NPORT_DEF = 7;
  localparam logic [6:0] PHY_MASK_DEF = 7'h1f;

  // ********************************************************************
  // Control byte layout and reset values.
  // ********************************************************************
  localparam int TAIL_BIT = 2;
  localparam int SPLIT_LSB = 0;
  localparam int SPLIT_MSB = 1;
  localparam logic TAIL_RST = 1'h0;
  localparam logic [1:0] SPLIT_RST = 2'h0;

  // ********************************************************************
  // Status byte layout.
  // ********************************************************************
  localparam int STAT_SPEED_LSB = 3;
  localparam int STAT_SPEED_MSB = 4;
  localparam int STAT_DUPLEX_BIT = 2;
  localparam int STAT_TXFC_BIT = 1;
  localparam int STAT_RXFC_BIT = 0;
  localparam logic [2:0] STAT_RSVD = 3'h0;

  // ********************************************************************
  // External port control bits that the status byte mirrors.
  // ********************************************************************
  localparam int EXT1_SPEED_BIT = 6;
  localparam int EXT0_SPEED_BIT = 4;
  localparam int EXT0_DUPLEX_BIT = 6;
  localparam int EXT0_TXFC_BIT = 5;
  localparam int EXT0_RXFC_BIT = 3;

  // ********************************************************************
  // Modes and carriers.
  // ********************************************************************
  typedef enum logic [1:0] {
    SPLIT_SINGLE,
    SPLIT_TWO,
    SPLIT_FOUR,
    SPLIT_RSVD
  } pqls_split_e;

  typedef enum logic [1:0] {
    SPEED_10,
    SPEED_100,
    SPEED_1000
  } pqls_speed_e;

  typedef struct packed {
    logic link_up;
    logic [1:0] speed;
    logic duplex;
    logic tx_fc_agreed;
    logic rx_fc_agreed;
    logic [1:0] adv_fc;
  } pqls_phy_s;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl0;
  } pqls_ext_s;

endpackage

/* pqls_regs.sv */
// Per-port queue control and link status register bank with a classic Wishbone slave.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Writing 1 to a port's tail-tag bit enables tail tagging there and writing 0 disables it.
// - The two-bit queue split field resets to 00 and picks one, two or four queues, 11 reserved.
// - Each of ports 1 to 7 has an 8-bit status register at its per-port status offset.
// - On transceiver ports the speed field shows the real link speed, 00/01/10 = 10/100/1000.
// - On external MAC ports the speed field copies control 1 bit 6 and control 0 bit 4.
// - On external MAC ports the duplex bit copies control 0 bit 6, 1 meaning full duplex.
// - On transceiver ports the duplex bit shows the real link duplex, 1 meaning full duplex.
// - On external MAC ports the transmit flow-control bit copies control 0 bit 5.
// - On external MAC ports the receive flow-control bit copies control 0 bit 3.
// - On transceiver ports transmit flow control is 1 only if advertised, link up and agreed.
// - On transceiver ports receive flow control is 1 only if advertised, link up and agreed.
// - The transceiver register page exists only on transceiver ports, not external MAC ports.
module pqls_regs #(
  parameter int NPORT = pqls_pkg::NPORT_DEF,
  parameter logic [6:0] PHY_MASK = pqls_pkg::PHY_MASK_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [pqls_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [pqls_pkg::DAT_W-1:0] dat_i,
  output logic [pqls_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire pqls_pkg::pqls_phy_s [NPORT:1] phy_i,
  input wire pqls_pkg::pqls_ext_s [NPORT:1] ext_i,
  output logic [NPORT:1] tail_tag_en_o,
  output logic [NPORT:1][1:0] queue_split_o
);

  // ********************************************************************
  // Status encoding.
  // ********************************************************************
  function automatic logic [7:0] phy_status(input pqls_pkg::pqls_phy_s p);
    logic fc_ok;
    fc_ok = (|p.adv_fc) & p.link_up;
    phy_status = {pqls_pkg::STAT_RSVD, p.speed, p.duplex,
                  fc_ok & p.tx_fc_agreed, fc_ok & p.rx_fc_agreed};
  endfunction

  function automatic logic [7:0] ext_status(input pqls_pkg::pqls_ext_s e);
    ext_status = {pqls_pkg::STAT_RSVD,
                  e.ctrl1[pqls_pkg::EXT1_SPEED_BIT],
                  e.ctrl0[pqls_pkg::EXT0_SPEED_BIT],
                  e.ctrl0[pqls_pkg::EXT0_DUPLEX_BIT],
                  e.ctrl0[pqls_pkg::EXT0_TXFC_BIT],
                  e.ctrl0[pqls_pkg::EXT0_RXFC_BIT]};
  endfunction

  localparam logic [2:0] LAST_PORT = 3'(NPORT);

  // ********************************************************************
  // Address decode.
  // ********************************************************************
  wire logic [2:0] acc_port;
  wire logic [2:0] acc_idx;
  wire logic [11:0] acc_ofs;
  wire logic port_ok;
  wire logic port_is_phy;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic hit_page;
  wire logic hit_any;
  wire logic req;
  wire logic wr_ctrl;
  wire logic rd_stat;
  wire logic [7:0] ctrl_byte;
  wire logic [7:0] stat_byte;
  wire logic [pqls_pkg::DAT_W-1:0] rd_mux;
  logic [NPORT:1][7:0] status;

  assign acc_port = adr_i[14:12];
  assign acc_ofs = adr_i[11:0];
  assign port_ok = ~adr_i[15] & (acc_port >= pqls_pkg::FIRST_PORT) & (acc_port <= LAST_PORT);
  assign acc_idx = port_ok ? acc_port : pqls_pkg::FIRST_PORT;
  assign port_is_phy = port_ok & PHY_MASK[acc_port - pqls_pkg::FIRST_PORT];
  assign hit_ctrl = port_ok & (acc_ofs == pqls_pkg::CTRL_OFS);
  assign hit_stat = port_ok & (acc_ofs == pqls_pkg::STAT_OFS);
  assign hit_page = port_is_phy & (acc_ofs[11:8] == pqls_pkg::PHY_PAGE);
  assign hit_any = hit_ctrl | hit_stat | hit_page;
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr_ctrl = cyc_i & stb_i & ack_o & we_i & sel_i[0] & hit_ctrl;
  assign rd_stat = req & ~we_i & hit_stat;

  // ********************************************************************
  // Per-port status bytes.
  // ********************************************************************
  for (genvar p = 1; p <= NPORT; p++) begin : g_port
    always_comb begin
      if (PHY_MASK[p-1]) begin
        status[p] = phy_status(phy_i[p]);
      end else begin
        status[p] = ext_status(ext_i[p]);
      end
    end
  end

  // ********************************************************************
  // Read selection.
  // ********************************************************************
  assign ctrl_byte = {5'h00, tail_tag_en_o[acc_idx], queue_split_o[acc_idx]};
  assign stat_byte = status[acc_idx];
  assign rd_mux = hit_ctrl ? {24'h000000, ctrl_byte} :
                  hit_stat ? {24'h000000, stat_byte} : 32'h00000000;

  // ********************************************************************
  // Bus answer.
  // ********************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'h0;
      err_o <= 1'h0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req & hit_any;
      err_o <= req & ~hit_any;
      if (req) begin
        dat_o <= we_i ? 32'h00000000 : rd_mux;
      end
    end
  end

  // ********************************************************************
  // Control registers.
  // ********************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tail_tag_en_o <= {NPORT{pqls_pkg::TAIL_RST}};
      queue_split_o <= {NPORT{pqls_pkg::SPLIT_RST}};
    end else if (wr_ctrl) begin
      tail_tag_en_o[acc_idx] <= dat_i[pqls_pkg::TAIL_BIT];
      queue_split_o[acc_idx] <= dat_i[pqls_pkg::SPLIT_MSB:pqls_pkg::SPLIT_LSB];
    end
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  a_tail_tag_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> tail_tag_en_o[$past(acc_port)] == $past(dat_i[pqls_pkg::TAIL_BIT]))
    else $error("Tail tag bit did not follow the write.");

  a_split_reset_value: assert property (
    @(posedge clk_i)
    rst_i |=> (queue_split_o == '0) && (tail_tag_en_o == '0))
    else $error("Control fields not cleared by reset.");

  a_split_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> queue_split_o[$past(acc_port)] == $past(dat_i[1:0]))
    else $error("Queue split field did not follow the write.");

  a_status_answer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && hit_stat) |=> ack_o && !err_o ##1 !ack_o)
    else $error("Status access not acknowledged for one cycle.");

  a_phy_speed: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && port_is_phy) |=> dat_o[4:3] == $past(phy_i[acc_port].speed))
    else $error("Transceiver speed field wrong.");

  a_ext_speed: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && !port_is_phy) |=>
      dat_o[4:3] == {$past(ext_i[acc_port].ctrl1[6]), $past(ext_i[acc_port].ctrl0[4])})
    else $error("External port speed field wrong.");

  a_ext_duplex: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && !port_is_phy) |=> dat_o[2] == $past(ext_i[acc_port].ctrl0[6]))
    else $error("External port duplex bit wrong.");

  a_phy_duplex: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && port_is_phy) |=> dat_o[2] == $past(phy_i[acc_port].duplex))
    else $error("Transceiver duplex bit wrong.");

  a_ext_tx_fc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && !port_is_phy) |=> dat_o[1] == $past(ext_i[acc_port].ctrl0[5]))
    else $error("External port transmit flow control bit wrong.");

  a_ext_rx_fc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && !port_is_phy) |=> dat_o[0] == $past(ext_i[acc_port].ctrl0[3]))
    else $error("External port receive flow control bit wrong.");

  a_phy_tx_fc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && port_is_phy) |=> dat_o[1] == ($past(|phy_i[acc_port].adv_fc) &&
      $past(phy_i[acc_port].link_up) && $past(phy_i[acc_port].tx_fc_agreed)))
    else $error("Transceiver transmit flow control bit wrong.");

  a_phy_rx_fc: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && port_is_phy) |=> dat_o[0] == ($past(|phy_i[acc_port].adv_fc) &&
      $past(phy_i[acc_port].link_up) && $past(phy_i[acc_port].rx_fc_agreed)))
    else $error("Transceiver receive flow control bit wrong.");

  a_page_ext_refused: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && port_ok && !port_is_phy && acc_ofs[11:8] == 4'h1) |=> err_o && !ack_o)
    else $error("Transceiver page answered on an external port.");

  a_status_read_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat |=> dat_o[31:5] == 27'h0000000) and
    ((req && we_i && hit_stat) |=> ##1 $stable(tail_tag_en_o) && $stable(queue_split_o)))
    else $error("Status register not read only.");

  // ********************************************************************
  // Bus protocol checks.
  // ********************************************************************
  a_ack_pulse_once: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Acknowledge stood longer than one cycle.");

  a_err_pulse_once: assert property (
    @(posedge clk_i) disable iff (rst_i)
    err_o |=> !err_o)
    else $error("Error stood longer than one cycle.");

  a_ack_err_apart: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(ack_o && err_o))
    else $error("Acknowledge and error raised together.");

  a_bus_idle_reset: assert property (
    @(posedge clk_i)
    rst_i |=> !ack_o && !err_o && (dat_o == '0))
    else $error("Bus outputs not cleared by reset.");

  a_ack_needs_req: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |-> $past(req))
    else $error("Acknowledge without a request.");

  a_err_needs_req: assert property (
    @(posedge clk_i) disable iff (rst_i)
    err_o |-> $past(req))
    else $error("Error without a request.");

  a_unmapped_refused: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !hit_any) |=> err_o && !ack_o)
    else $error("Unmapped access not refused.");

  a_mapped_acked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && hit_any) |=> ack_o && !err_o)
    else $error("Mapped access not acknowledged.");

  a_no_answer_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o && !err_o)
    else $error("Answer given with no request.");

  a_dat_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !req |=> $stable(dat_o))
    else $error("Read data changed between accesses.");

  a_ack_upper_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("Upper read data bits not zero.");

  // ********************************************************************
  // Control register checks.
  // ********************************************************************
  a_ctrl_read_value: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_ctrl) |=>
      dat_o[2:0] == {tail_tag_en_o[$past(acc_idx)], queue_split_o[$past(acc_idx)]})
    else $error("Control byte read back wrong.");

  a_ctrl_upper_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_ctrl) |=> dat_o[31:3] == '0)
    else $error("Unused control bits not zero.");

  a_tail_tag_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && !dat_i[2]) |=> !tail_tag_en_o[$past(acc_idx)])
    else $error("Tail tag not cleared by a zero write.");

  a_split_reserved_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && dat_i[1:0] == 2'h3) |=> queue_split_o[$past(acc_idx)] == 2'h3)
    else $error("Reserved split value not stored.");

  a_sel_gates_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && ack_o && we_i && hit_ctrl && !sel_i[0]) |=>
      $stable(tail_tag_en_o) && $stable(queue_split_o))
    else $error("Control changed by a write without byte select.");

  a_ctrl_only_on_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !wr_ctrl |=> $stable(tail_tag_en_o) && $stable(queue_split_o))
    else $error("Control changed without a write.");

  a_read_no_effect: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i) |=> ##1 $stable(tail_tag_en_o) && $stable(queue_split_o))
    else $error("Control changed by a read.");

  a_err_no_effect: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !hit_any) |=> ##1 $stable(tail_tag_en_o) && $stable(queue_split_o))
    else $error("Control changed by a refused access.");

  // ********************************************************************
  // Status and page checks.
  // ********************************************************************
  a_status_rsvd_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    port_ok |-> stat_byte[7:5] == 3'h0)
    else $error("Reserved status bits not zero.");

  a_phy_fc_needs_link: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && port_is_phy && !phy_i[acc_idx].link_up) |=> dat_o[1:0] == 2'h0)
    else $error("Flow control shown with link down.");

  a_phy_fc_needs_adv: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_stat && port_is_phy && phy_i[acc_idx].adv_fc == 2'h0) |=> dat_o[1:0] == 2'h0)
    else $error("Flow control shown while not advertised.");

  a_page_reads_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_page) |=> ack_o && (dat_o == '0))
    else $error("Transceiver page read not zero.");

  a_write_reads_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && we_i) |=> dat_o == '0)
    else $error("Write answer carried data.");

endmodule

`default_nettype wire

/* pqls_tb.sv */
// Self-checking testbench for the port queue control and link status register bank.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ****************************************************************
  // Signals and design instance.
  // ****************************************************************
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [15:0] adr = 16'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic err;
  pqls_pkg::pqls_phy_s [7:1] phy = '0;
  pqls_pkg::pqls_ext_s [7:1] ext = '0;
  logic [7:1] tail_tag;
  logic [7:1][1:0] split;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;
  logic [34:0] rows [6] = '{{3'h1, 8'hbd, 16'hffff, 8'h0f}, {3'h2, 8'h3d, 16'hffff, 8'h0c},
    {3'h3, 8'hcc, 16'hffff, 8'h10}, {3'h5, 8'h9a, 16'hffff, 8'h06},
    {3'h6, 8'hff, 16'h4048, 8'h15}, {3'h7, 8'hff, 16'hbf30, 8'h0a}};
  pqls_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .err_o(err),
    .phy_i(phy), .ext_i(ext), .tail_tag_en_o(tail_tag), .queue_split_o(split));
  // ****************************************************************
  // Clock, timeout and shared tasks.
  // ****************************************************************
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int k;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      k = k + 1;
    end while (ack !== 1'h1 && err !== 1'h1 && k < 20);
    if (k >= 20) check(32'h0, 32'h1);
    q = dat_r;
    e = err;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d.", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    check({tail_tag, split}, 21'h0);
    bus(1'h0, 16'h1020, 32'h0, 4'h1);
    check(q, 32'h0);
    // The status table drives both input kinds so that the ignored one is noise.
    foreach (rows[i]) begin
      phy[rows[i][34:32]] <= rows[i][31:24];
      ext[rows[i][34:32]] <= rows[i][23:8];
      bus(1'h0, {1'h0, rows[i][34:32], 12'h030}, 32'h0, 4'h1);
      check({e, q}, {25'h0, rows[i][7:0]});
    end
    bus(1'h1, 16'h7030, 32'hff, 4'hf);
    bus(1'h0, 16'h7030, 32'h0, 4'h1);
    check(q, 32'h0a);
    for (int v = 0; v < 8; v++) begin
      bus(1'h1, 16'h3020, v, 4'h1);
      check({tail_tag[3], split[3], tail_tag[4], split[4]}, {v[2:0], 3'h0});
      bus(1'h0, 16'h3020, 32'h0, 4'h1);
      check(q, v);
    end
    bus(1'h1, 16'h3020, 32'h0, 4'h0);
    check({tail_tag[3], split[3]}, 3'h7);
    bus(1'h0, 16'h2100, 32'h0, 4'h1);
    check({e, q}, 33'h0);
    bus(1'h0, 16'h6100, 32'h0, 4'h1);
    check(e, 1'h1);
    bus(1'h0, 16'h1040, 32'h0, 4'h1);
    check(e, 1'h1);
    bus(1'h0, 16'h0030, 32'h0, 4'h1);
    check(e, 1'h1);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    check({tail_tag, split}, 21'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
